// >>> shared/mcc_pkg.sv
// Package of constants for the monitor control configuration bank
package mcc_pkg;
    localparam logic [7:0] ADDR_CFG_ONE = 8'h18;
    localparam logic [7:0] ADDR_CFG_TWO = 8'h19;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // First register fields
    localparam int ONE_START_BIT = 0;
    localparam int ONE_ALERT_DIS_BIT = 5;
    localparam int ONE_ALERT_POL_BIT = 6;
    localparam int ONE_STANDBY_BIT = 7;
    localparam logic [7:0] ONE_RSVD_MASK = 8'h1e;
    // Second register fields
    localparam int TWO_SRC_LSB = 0;
    localparam int TWO_SINGLE_BIT = 4;
    localparam int TWO_AVG_DIS_BIT = 5;
    localparam int TWO_TIMEOUT_EN_BIT = 6;
    localparam int TWO_SWRST_BIT = 7;
    localparam int AVG_COUNT = 16;
    // Timeout on a serial clock pulse
    localparam int CLK_MHZ = 125;
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int TMO_W = 22;
    typedef enum logic [1:0] {
        SRC_SUPPLY = 2'b00,
        SRC_INT_TEMP = 2'b01,
        SRC_EXT_TEMP = 2'b10,
        SRC_RESERVED = 2'b11
    } mcc_src_t;
endpackage

// >>> shared/mcc_tmo_if.sv
// Interface between the bank and the clock timeout watchdog
`timescale 1ns/1ps
interface mcc_tmo_if;
    logic enable;
    logic sclLow;
    logic expired;
    modport bank (output enable, output sclLow, input expired);
    modport dog (input enable, input sclLow, output expired);
endinterface

// >>> rtl/mcc_timeout.sv
// Watchdog on the width of a low serial clock pulse
`timescale 1ns/1ps
module mcc_timeout
    import mcc_pkg::*;
#(
    parameter logic [TMO_W-1:0] LIMIT = TMO_W'(TIMEOUT_CYCLES)
) (
    input wire logic sys_clk, // System clock
    input wire logic rst_b, // Synchronous reset, low
    mcc_tmo_if.dog tmo // Control and result
);
    logic [TMO_W-1:0] count_reg;
    logic [TMO_W-1:0] count_next;
    logic expired_reg;
    logic expired_next;

    // Count while enabled and clock held low
    always_comb begin
        count_next = '0;
        expired_next = 1'b0;
        if (tmo.enable && tmo.sclLow) begin
            expired_next = expired_reg || (count_reg == LIMIT - 1'b1);
            count_next = expired_next ? count_reg : count_reg + 1'b1;
        end
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            count_reg <= '0;
            expired_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            expired_reg <= expired_next;
        end
    end

    assign tmo.expired = expired_reg;

    chk_expiry_needs_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tmo.expired |-> $past(tmo.enable) && $past(tmo.sclLow))
        else $error("timeout flagged without enabled low clock");
endmodule

// >>> rtl/mcc_bank.sv
// Control configuration register pair of the monitor
// Behaviour
// - Both registers are 8-bit read/write and reset to zero; first register bits 4:1 and second register bit 7 always read zero.
// - First register bit 0 starts conversions while bit 7 is clear; cleared stops them.
// - First register bit 5 set disables the alert output.
// - First register bit 6 selects alert polarity: 0 low, 1 high.
// - First register bit 7 enters standby; serial interface keeps working.
// - Second register bits 1:0 pick single-channel source; code 11 reserved.
// - Second register bit 4: 0 round-robin, 1 single channel.
// - Averaging over 16 conversions unless second register bit 5 set.
// - Second register bit 6 enables 25 ms clock timeout releasing data line.
// - Writing one to second register bit 7 resets registers and DAC outputs.
`timescale 1ns/1ps
module mcc_bank
    import mcc_pkg::*;
(
    input wire logic sys_clk, // System clock, 125 MHz
    input wire logic rst_b, // Synchronous reset, low
    input wire logic regWrite, // Write strobe from serial engine
    input wire logic [7:0] regAddr, // Register pointer
    input wire logic [7:0] regWdata, // Write data
    output logic [7:0] regRdata, // Read data for pointer
    input wire logic alertEvent, // Raw alert condition, high true
    output logic alertPin, // Alert output level
    input wire logic sclIn, // Serial clock as sampled
    input wire logic sdaDriveReq, // Serial engine wants data line low
    output logic sdaOe, // Data line pull-low enable
    output logic convRun, // Conversions enabled
    output logic standby_request, // Converter and DACs powered down
    output logic singleChannel, // Single-channel sequence
    output logic [1:0] channelSel, // Single-channel source
    output logic averageOn, // Averaging over 16 conversions
    output logic [4:0] avgCount, // Conversions per measurement
    output logic softReset // One-cycle reset of registers and DACs
);
    logic [7:0] cfgOne_reg;
    logic [7:0] cfgOne_next;
    logic [7:0] cfgTwo_reg;
    logic [7:0] cfgTwo_next;
    logic swrst_reg;
    logic swrst_next;
    logic alert_reg;
    logic alert_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic sdaOe_reg;
    logic sdaOe_next;
    logic alertLevel;
    mcc_tmo_if tmo ();

    function automatic logic hitAddr(input logic [7:0] addr, input logic [7:0] target);
        hitAddr = (addr == target);
    endfunction

    // Register writes and software reset
    always_comb begin
        cfgOne_next = cfgOne_reg;
        cfgTwo_next = cfgTwo_reg;
        swrst_next = 1'b0;
        if (swrst_reg) begin
            cfgOne_next = CFG_RESET;
            cfgTwo_next = CFG_RESET;
        end else if (regWrite && hitAddr(regAddr, ADDR_CFG_ONE)) begin
            cfgOne_next = regWdata & ~ONE_RSVD_MASK;
        end else if (regWrite && hitAddr(regAddr, ADDR_CFG_TWO)) begin
            cfgTwo_next = regWdata;
            cfgTwo_next[TWO_SWRST_BIT] = 1'b0;
            swrst_next = regWdata[TWO_SWRST_BIT];
        end
    end

    // Read path and alert output
    always_comb begin
        rdata_next = 8'h00;
        if (hitAddr(regAddr, ADDR_CFG_ONE)) begin
            rdata_next = cfgOne_reg;
        end else if (hitAddr(regAddr, ADDR_CFG_TWO)) begin
            rdata_next = cfgTwo_reg;
        end
        alertLevel = alertEvent && !cfgOne_reg[ONE_ALERT_DIS_BIT];
        alert_next = cfgOne_reg[ONE_ALERT_POL_BIT] ? alertLevel : !alertLevel;
        sdaOe_next = sdaDriveReq && !tmo.expired;
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cfgOne_reg <= CFG_RESET;
            cfgTwo_reg <= CFG_RESET;
            swrst_reg <= 1'b0;
            alert_reg <= 1'b1;
            rdata_reg <= 8'h00;
            sdaOe_reg <= 1'b0;
        end else begin
            cfgOne_reg <= cfgOne_next;
            cfgTwo_reg <= cfgTwo_next;
            swrst_reg <= swrst_next;
            alert_reg <= alert_next;
            rdata_reg <= rdata_next;
            sdaOe_reg <= sdaOe_next;
        end
    end

    // Timeout watchdog
    assign tmo.enable = cfgTwo_reg[TWO_TIMEOUT_EN_BIT];
    assign tmo.sclLow = !sclIn;
    mcc_timeout u_timeout (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .tmo(tmo)
    );

    // Mode outputs
    assign convRun = cfgOne_reg[ONE_START_BIT] && !cfgOne_reg[ONE_STANDBY_BIT];
    assign standby_request = cfgOne_reg[ONE_STANDBY_BIT];
    assign singleChannel = cfgTwo_reg[TWO_SINGLE_BIT];
    assign channelSel = cfgTwo_reg[TWO_SRC_LSB +: 2];
    assign averageOn = !cfgTwo_reg[TWO_AVG_DIS_BIT];
    assign avgCount = averageOn ? 5'(AVG_COUNT) : 5'h01;
    assign softReset = swrst_reg;
    assign alertPin = alert_reg;
    assign regRdata = rdata_reg;
    assign sdaOe = sdaOe_reg;

    chk_reset_zeroes: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(rst_b) |-> cfgOne_reg == 8'h00 && cfgTwo_reg == 8'h00)
        else $error("registers not zero after reset");
    chk_no_run_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        convRun |-> cfgOne_reg[0])
        else $error("conversions run while start bit clear");
    chk_alert_disabled: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $past(cfgOne_reg[5]) && $past(cfgOne_reg[5], 2) |-> alertPin == !$past(cfgOne_reg[6]))
        else $error("disabled alert shows asserted level");
    chk_alert_polarity: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !cfgOne_reg[5] && $stable(cfgOne_reg) ##1 1'b1 |-> alertPin == ($past(alertEvent) ~^ $past(cfgOne_reg[6])))
        else $error("alert polarity wrong");
    chk_standby_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
        regWrite && regAddr == 8'h18 && !swrst_reg |=> standby_request == $past(regWdata[7]))
        else $error("standby not following write");
    chk_mode_select: assert property (@(posedge sys_clk) disable iff (!rst_b)
        regWrite && regAddr == 8'h19 && !swrst_reg |=> singleChannel == $past(regWdata[4])
        && channelSel == $past(regWdata[1:0]))
        else $error("mode or source not following write");
    chk_avg_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
        avgCount == (cfgTwo_reg[5] ? 5'd1 : 5'd16))
        else $error("averaging count wrong");
    chk_sda_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tmo.expired |=> !sdaOe)
        else $error("data line held after timeout");
    chk_soft_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
        regWrite && regAddr == 8'h19 && regWdata[7] && !swrst_reg |=> softReset ##1
        (cfgOne_reg == 8'h00 && cfgTwo_reg == 8'h00 && !softReset))
        else $error("software reset did not clear registers");
endmodule

// >>> tb/mcc_host_model.sv
// Serial host model: clock pulses and data pull-low requests
`timescale 1ns/1ps
module mcc_host_model (
    input wire logic sys_clk, // System clock
    input wire logic rst_b, // Synchronous reset, low
    input wire logic sclRun, // Run a frame of clock pulses
    output logic sclIn, // Serial clock, idles high on pull-up
    output logic sdaDriveReq // Data line pull-low request
);
    logic [1:0] divReg;
    // Clock stands high outside frames, toggles every 4 cycles inside
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !sclRun) begin
            divReg <= 2'h0;
            sclIn <= 1'b1;
        end else begin
            divReg <= divReg + 2'h1;
            if (divReg == 2'h3) sclIn <= ~sclIn;
        end
    end
    assign sdaDriveReq = sclRun & ~sclIn; // Pull low only in low phase
endmodule

// >>> tb/tb_top.sv
// Self-checking bench of the control configuration bank
`timescale 1ns/1ps
module tb_top;
    import mcc_pkg::*;
    logic sys_clk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, alertEvent = 1'b0, sclRun = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
    logic alertPin, sclIn, sdaDriveReq, sdaOe, convRun, standby_request, singleChannel, averageOn, softReset;
    logic [1:0] channelSel;
    logic [4:0] avgCount;
    int n_errors = 0, total_checks = 0;
    always #4 sys_clk = ~sys_clk;
    mcc_bank dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .alertEvent(alertEvent), .alertPin(alertPin),
        .sclIn(sclIn), .sdaDriveReq(sdaDriveReq), .sdaOe(sdaOe), .convRun(convRun),
        .standby_request(standby_request), .singleChannel(singleChannel), .channelSel(channelSel),
        .averageOn(averageOn), .avgCount(avgCount), .softReset(softReset));
    mcc_host_model host_u (.sys_clk(sys_clk), .rst_b(rst_b), .sclRun(sclRun), .sclIn(sclIn),
        .sdaDriveReq(sdaDriveReq));
    // Compare and count
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One write strobe, outputs settled after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    // Point at a register and compare registered read data
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        repeat (2) @(posedge sys_clk);
        #1 chk("regRdata", regRdata, exp);
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(ADDR_CFG_ONE, 8'h00);
        rd(ADDR_CFG_TWO, 8'h00);
        chk("avgCount", {3'h0, avgCount}, 8'h10);
        chk("convRun", {7'h0, convRun}, 8'h00);
        chk("averageOn", {7'h0, averageOn}, 8'h01);
        wr(ADDR_CFG_ONE, 8'h81);
        chk("standby", {7'h0, standby_request}, 8'h01);
        chk("convRun", {7'h0, convRun}, 8'h00);
        wr(ADDR_CFG_ONE, 8'h01);
        chk("convRun", {7'h0, convRun}, 8'h01);
        rd(ADDR_CFG_ONE, 8'h01);
        // Alert polarity and gating
        wr(ADDR_CFG_ONE, 8'h40);
        alertEvent <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 chk("alertHigh", {7'h0, alertPin}, 8'h01);
        wr(ADDR_CFG_ONE, 8'h60);
        repeat (2) @(posedge sys_clk);
        #1 chk("alertOff", {7'h0, alertPin}, 8'h00);
        wr(ADDR_CFG_ONE, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1 chk("alertLow", {7'h0, alertPin}, 8'h00);
        alertEvent <= 1'b0;
        // Every source code in single-channel mode
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CFG_TWO, 8'h10 | 8'(c));
            chk("channelSel", {6'h0, channelSel}, 8'(c));
            chk("single", {7'h0, singleChannel}, 8'h01);
        end
        wr(ADDR_CFG_TWO, 8'h20);
        chk("single", {7'h0, singleChannel}, 8'h00);
        chk("avgCount", {3'h0, avgCount}, 8'h01);
        chk("averageOn", {7'h0, averageOn}, 8'h00);
        // Timeout enabled with a healthy clock keeps the data line usable
        wr(ADDR_CFG_TWO, 8'h40);
        sclRun <= 1'b1;
        wait (sdaDriveReq === 1'b1);
        repeat (2) @(posedge sys_clk);
        #1 chk("sdaOe", {7'h0, sdaOe}, 8'h01);
        sclRun <= 1'b0;
        rd(8'h20, 8'h00);
        // Software reset clears both registers and itself
        wr(ADDR_CFG_ONE, 8'h41);
        wr(ADDR_CFG_TWO, 8'h80);
        chk("softReset", {7'h0, softReset}, 8'h01);
        rd(ADDR_CFG_ONE, 8'h00);
        rd(ADDR_CFG_TWO, 8'h00);
        chk("softReset", {7'h0, softReset}, 8'h00);
        summarize();
    end
endmodule
